/* src/tfre_defs.svh */
`ifndef TFRE_DEFS_SVH
`define TFRE_DEFS_SVH

// Field codes
`define TFRE_F_DEST_MAC 8'h01
`define TFRE_F_SOURCE_MAC 8'h02
`define TFRE_F_ETYPE 8'h03
`define TFRE_F_OUTER_TAG 8'h04
`define TFRE_F_OUTER_TPID 8'h05
`define TFRE_F_OUTER_VID 8'h06
`define TFRE_F_INNER_TAG 8'h07
`define TFRE_F_INNER_TPID 8'h08
`define TFRE_F_INNER_VID 8'h09
`define TFRE_F_PAYLOAD_KIND 8'h0A

// Condition operators
`define TFRE_OP_NOP 8'h00
`define TFRE_OP_PRESENT 8'hE1
`define TFRE_OP_ABSENT 8'hE0
`define TFRE_OP_EQ 8'h11
`define TFRE_OP_NE 8'h10
`define TFRE_OP_TRUE 8'hA1

// Action codes
`define TFRE_ACT_ADD 8'hAD
`define TFRE_ACT_DELETE 8'hDE
`define TFRE_ACT_CHANGE 8'hCE

// Header layout
`define TFRE_TPID_DEFAULT 16'h8100
`define TFRE_VID_W 12
`define TFRE_FIELD_W 48

`endif

/* src/tfre_pkg.sv */
package tfre_pkg;
    typedef logic [7:0] tfre_code_t;

    // Parsed header; tags are {tpid, tci}
    typedef struct packed {
        logic [47:0] dest_mac;
        logic [47:0] source_mac;
        logic outer_present;
        logic [31:0] outer_tag;
        logic inner_present;
        logic [31:0] inner_tag;
        logic [15:0] ethertype_length;
        logic kind_present;
        logic [7:0] tunnel_payload_kind;
    } tfre_hdr_t;

    typedef struct packed {
        tfre_code_t op;
        tfre_code_t field;
        logic [47:0] value;
    } tfre_cond_t;

    typedef struct packed {
        tfre_code_t act;
        tfre_code_t field;
        logic [47:0] value;
    } tfre_action_t;

    typedef struct packed {
        logic hdr_changed;
        logic error;
        logic matched;
        logic [7:0] rule_index;
    } tfre_status_t;

    typedef enum logic [1:0] {
        TFRE_PORT_STATION,
        TFRE_PORT_MANAGER
    } tfre_port_role_t;

    typedef enum logic {
        TFRE_CAT_EXIT,
        TFRE_CAT_ENTRANCE
    } tfre_category_t;
endpackage : tfre_pkg

/* src/tfre_engine.sv */
// Summary of operation
// - Destination MAC is field code 01, 48 bits wide.
// - Source MAC is field code 02, 48 bits wide.
// - Outermost ethertype_length is field code 03, 16 bits.
// - Outer tag, code 04, first tag after source MAC; absent if none.
// - Outer tag protocol id is code 05, vlan id code 06.
// - Inner tag, code 07, tag following outer tag; absent if none.
// - Inner tag protocol id is code 08, vlan id code 09.
// - Payload kind, code 0A, 8 bits, only in tunnel frames after ethertype.
// - Each action modifies exactly one field named by its code.
// - Action AD inserts the indicated field with the supplied value.
// - Action DE removes the indicated field; missing field flags error.
// - Action CE overwrites the indicated field; missing field flags error.
// - A rule's actions apply one by one in listed order.
// - No action is ever performed on the source MAC.
// - Destination MAC and ethertype accept only the change action.
// - Deleting outer tag promotes inner tag; later inner delete fails.
// - Ingress and egress rule tables are separate, each on its own path.
// - Rules are tunnel exit or tunnel entrance category.
// - Station port: egress exit, ingress entrance; manager: the reverse.
// - A frame matching no rule passes unmodified.
// - Operators E1 present and E0 absent ignore the value operand.
// - Operators 11 equal, 10 not equal, A1 true; 00 acts as true.
`include "tfre_defs.svh"

module tfre_engine
    import tfre_pkg::*;
#(
    parameter int NUM_RULES = 4,
    parameter int NUM_CONDS = 4,
    parameter int NUM_ACTS = 4,
    parameter bit IS_EGRESS = 1'b0
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic reset_i,
    // Rule table, provisioned by management
    input wire logic [NUM_RULES-1:0] rule_valid_i,
    input wire tfre_category_t [NUM_RULES-1:0] rule_category_i,
    input wire tfre_cond_t [NUM_RULES-1:0][NUM_CONDS-1:0] rule_cond_i,
    input wire tfre_action_t [NUM_RULES-1:0][NUM_ACTS-1:0] rule_action_i,
    input wire tfre_port_role_t port_role_i,
    // Header in
    input wire logic hdr_valid_i,
    input wire tfre_hdr_t hdr_i,
    output logic hdr_ready_o,
    // Header out
    output logic hdr_valid_o,
    output tfre_hdr_t hdr_o,
    output tfre_status_t status_o,
    input wire logic hdr_ready_i
);

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ACT,
        ST_OUT
    } state_t;

    typedef struct packed {
        state_t state;
        tfre_hdr_t hdr;
        tfre_status_t status;
        logic [7:0] act_idx;
        logic [7:0] rule_sel;
    } tfre_state_t;

    tfre_state_t s_q;
    tfre_state_t s_d;

    ////////////////////////////////////////////////////////////////////////
    // Field extraction

    function automatic logic field_present(tfre_hdr_t h, tfre_code_t f);
        unique case (f)
            `TFRE_F_DEST_MAC, `TFRE_F_SOURCE_MAC, `TFRE_F_ETYPE: field_present = 1'b1;
            `TFRE_F_OUTER_TAG, `TFRE_F_OUTER_TPID, `TFRE_F_OUTER_VID:
                field_present = h.outer_present;
            `TFRE_F_INNER_TAG, `TFRE_F_INNER_TPID, `TFRE_F_INNER_VID:
                field_present = h.inner_present;
            `TFRE_F_PAYLOAD_KIND: field_present = h.kind_present;
            default: field_present = 1'b0;
        endcase
    endfunction : field_present

    function automatic logic [47:0] field_value(tfre_hdr_t h, tfre_code_t f);
        unique case (f)
            `TFRE_F_DEST_MAC: field_value = h.dest_mac;
            `TFRE_F_SOURCE_MAC: field_value = h.source_mac;
            `TFRE_F_ETYPE: field_value = {32'h0000_0000, h.ethertype_length};
            `TFRE_F_OUTER_TAG: field_value = {16'h0000, h.outer_tag};
            `TFRE_F_OUTER_TPID: field_value = {32'h0000_0000, h.outer_tag[31:16]};
            `TFRE_F_OUTER_VID: field_value = {36'h0_0000_0000, h.outer_tag[11:0]};
            `TFRE_F_INNER_TAG: field_value = {16'h0000, h.inner_tag};
            `TFRE_F_INNER_TPID: field_value = {32'h0000_0000, h.inner_tag[31:16]};
            `TFRE_F_INNER_VID: field_value = {36'h0_0000_0000, h.inner_tag[11:0]};
            `TFRE_F_PAYLOAD_KIND: field_value = {40'h00_0000_0000, h.tunnel_payload_kind};
            default: field_value = 48'h0000_0000_0000;
        endcase
    endfunction : field_value

    ////////////////////////////////////////////////////////////////////////
    // Conditions

    function automatic logic cond_true(tfre_hdr_t h, tfre_cond_t c);
        logic pres;
        logic [47:0] v;
        pres = field_present(h, c.field);
        v = field_value(h, c.field);
        unique case (c.op)
            `TFRE_OP_NOP, `TFRE_OP_TRUE: cond_true = 1'b1;
            `TFRE_OP_PRESENT: cond_true = pres;
            `TFRE_OP_ABSENT: cond_true = !pres;
            // Missing field never equals anything
            `TFRE_OP_EQ: cond_true = pres && (v == c.value);
            `TFRE_OP_NE: cond_true = pres && (v != c.value);
            default: cond_true = 1'b0;
        endcase
    endfunction : cond_true

    // Category allowed by port role and path direction
    function automatic logic category_ok(tfre_category_t cat, tfre_port_role_t role);
        logic want_exit;
        want_exit = (role == TFRE_PORT_STATION) ? IS_EGRESS : !IS_EGRESS;
        category_ok = (cat == TFRE_CAT_EXIT) ? want_exit : !want_exit;
    endfunction : category_ok

    logic [NUM_RULES-1:0] rule_hit;

    // This instance only holds its own path's table
    for (genvar r = 0; r < NUM_RULES; r++) begin : g_rule
        logic [NUM_CONDS-1:0] c_ok;
        for (genvar c = 0; c < NUM_CONDS; c++) begin : g_cond
            assign c_ok[c] = cond_true(hdr_i, rule_cond_i[r][c]);
        end
        assign rule_hit[r] = rule_valid_i[r] && (&c_ok)
            && category_ok(rule_category_i[r], port_role_i);
    end

    logic any_hit;
    logic [7:0] first_hit;

    // Lowest index wins: the downward scan writes the first hit last
    always_comb begin
        any_hit = 1'b0;
        first_hit = 8'h00;
        for (int r = NUM_RULES - 1; r >= 0; r--) begin
            if (rule_hit[r]) begin
                any_hit = 1'b1;
                first_hit = 8'(r);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Field restrictions

    // Source MAC is read-only; dest MAC and ethertype only take a change
    function automatic logic action_allowed(tfre_action_t a);
        logic known;
        known = (a.act == `TFRE_ACT_ADD) || (a.act == `TFRE_ACT_DELETE)
            || (a.act == `TFRE_ACT_CHANGE);
        unique case (a.field)
            `TFRE_F_SOURCE_MAC: action_allowed = !known;
            `TFRE_F_DEST_MAC, `TFRE_F_ETYPE:
                action_allowed = !known || (a.act == `TFRE_ACT_CHANGE);
            default: action_allowed = 1'b1;
        endcase
    endfunction : action_allowed

    ////////////////////////////////////////////////////////////////////////
    // Action application

    function automatic tfre_hdr_t apply_action(tfre_hdr_t h, tfre_action_t a,
                                               output logic err, output logic chg);
        tfre_hdr_t n;
        logic pres;
        n = h;
        err = 1'b0;
        chg = 1'b0;
        pres = field_present(h, a.field);
        unique case (a.act)
            `TFRE_ACT_CHANGE: begin
                if (!pres) begin
                    err = 1'b1;
                end else begin
                    chg = 1'b1;
                    unique case (a.field)
                        `TFRE_F_DEST_MAC: n.dest_mac = a.value;
                        `TFRE_F_ETYPE: n.ethertype_length = a.value[15:0];
                        `TFRE_F_OUTER_TAG: n.outer_tag = a.value[31:0];
                        `TFRE_F_OUTER_TPID: n.outer_tag[31:16] = a.value[15:0];
                        `TFRE_F_OUTER_VID: n.outer_tag[11:0] = a.value[11:0];
                        `TFRE_F_INNER_TAG: n.inner_tag = a.value[31:0];
                        `TFRE_F_INNER_TPID: n.inner_tag[31:16] = a.value[15:0];
                        `TFRE_F_INNER_VID: n.inner_tag[11:0] = a.value[11:0];
                        `TFRE_F_PAYLOAD_KIND: n.tunnel_payload_kind = a.value[7:0];
                        default: begin
                            err = 1'b1;
                            chg = 1'b0;
                        end
                    endcase
                end
            end
            `TFRE_ACT_DELETE: begin
                chg = 1'b1;
                unique case (a.field)
                    // Inner tag moves out, so a later inner delete misses
                    `TFRE_F_OUTER_TAG: begin
                        n.outer_tag = h.inner_tag;
                        n.outer_present = h.inner_present;
                        n.inner_present = 1'b0;
                        n.inner_tag = 32'h0000_0000;
                        err = !h.outer_present;
                    end
                    `TFRE_F_INNER_TAG: begin
                        n.inner_present = 1'b0;
                        n.inner_tag = 32'h0000_0000;
                        err = !h.inner_present;
                    end
                    `TFRE_F_PAYLOAD_KIND: begin
                        n.kind_present = 1'b0;
                        err = !h.kind_present;
                    end
                    default: err = 1'b1;
                endcase
                if (err) begin
                    n = h;
                    chg = 1'b0;
                end
            end
            `TFRE_ACT_ADD: begin
                chg = 1'b1;
                unique case (a.field)
                    // New tag goes outermost, pushing an existing outer tag inward; refused if an inner tag exists
                    `TFRE_F_OUTER_TAG: begin
                        err = h.inner_present;
                        n.inner_tag = h.outer_tag;
                        n.inner_present = h.outer_present;
                        n.outer_tag = a.value[31:0];
                        n.outer_present = 1'b1;
                    end
                    `TFRE_F_INNER_TAG: begin
                        err = h.inner_present;
                        // With no outer tag the new one is the only tag, hence outer
                        if (h.outer_present) begin
                            n.inner_tag = a.value[31:0];
                            n.inner_present = 1'b1;
                        end else begin
                            n.outer_tag = a.value[31:0];
                            n.outer_present = 1'b1;
                        end
                    end
                    `TFRE_F_PAYLOAD_KIND: begin
                        err = h.kind_present;
                        n.tunnel_payload_kind = a.value[7:0];
                        n.kind_present = 1'b1;
                    end
                    default: err = 1'b1;
                endcase
                if (err) begin
                    n = h;
                    chg = 1'b0;
                end
            end
            default: ;
        endcase
        // Checked last so no field decode can slip a restricted write through
        if (!action_allowed(a)) begin
            n = h;
            err = 1'b1;
            chg = 1'b0;
        end
        apply_action = n;
    endfunction : apply_action

    ////////////////////////////////////////////////////////////////////////
    // Sequencer

    // Table is read live while actions run, so it must hold until the result is taken
    tfre_action_t cur_act;
    logic act_err;
    logic act_chg;
    tfre_hdr_t act_hdr;

    always_comb begin
        cur_act = rule_action_i[s_q.rule_sel[$clog2(NUM_RULES > 1 ? NUM_RULES : 2)-1:0]]
                               [s_q.act_idx[$clog2(NUM_ACTS > 1 ? NUM_ACTS : 2)-1:0]];
        act_hdr = apply_action(s_q.hdr, cur_act, act_err, act_chg);
    end

    always_comb begin
        s_d = s_q;
        unique case (s_q.state)
            ST_IDLE: begin
                if (hdr_valid_i) begin
                    s_d.hdr = hdr_i;
                    s_d.status = '0;
                    s_d.status.matched = any_hit;
                    s_d.status.rule_index = first_hit;
                    s_d.rule_sel = first_hit;
                    s_d.act_idx = 8'h00;
                    s_d.state = any_hit ? ST_ACT : ST_OUT;
                end
            end
            // One action per cycle keeps a single field writer in the datapath
            ST_ACT: begin
                s_d.hdr = act_hdr;
                s_d.status.error = s_q.status.error | act_err;
                s_d.status.hdr_changed = s_q.status.hdr_changed | act_chg;
                s_d.act_idx = s_q.act_idx + 8'h01;
                if (s_q.act_idx == 8'(NUM_ACTS - 1)) begin
                    s_d.state = ST_OUT;
                end
            end
            ST_OUT: begin
                if (hdr_ready_i) begin
                    s_d.state = ST_IDLE;
                end
            end
            // Spare state code falls back to idle
            default: s_d.state = ST_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            s_q <= '{state: ST_IDLE, default: '0};
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs

    assign hdr_ready_o = (s_q.state == ST_IDLE);
    assign hdr_valid_o = (s_q.state == ST_OUT);
    assign hdr_o = s_q.hdr;
    assign status_o = s_q.status;

endmodule : tfre_engine

/* tb/tfre_sink.sv */
module tfre_sink (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic reset_i,
    // Result handshake
    input wire logic valid_i,
    input wire logic [3:0] stall_i,
    output logic ready_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] cnt_q;
    // Busy forwarding stage: ready only after stall_i waiting cycles
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            cnt_q <= 4'h0;
            ready_o <= 1'b0;
        end else if (valid_i && !ready_o && cnt_q >= stall_i) begin
            ready_o <= 1'b1;
        end else begin
            ready_o <= 1'b0;
            cnt_q <= (valid_i && !ready_o) ? cnt_q + 4'h1 : 4'h0;
        end
    end
endmodule : tfre_sink

/* tb/tfre_engine_sva.sv */
module tfre_engine_sva
    import tfre_pkg::*;
#(
    parameter int NUM_RULES = 4,
    parameter int NUM_ACTS = 4
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic reset_i,
    // Header handshakes
    input wire logic [NUM_RULES-1:0] rule_valid_i,
    input wire logic hdr_valid_i,
    input wire tfre_hdr_t hdr_i,
    input wire logic hdr_ready_o,
    input wire logic hdr_valid_o,
    input wire tfre_hdr_t hdr_o,
    input wire tfre_status_t status_o,
    input wire logic hdr_ready_i
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] cnt_q;
    tfre_hdr_t in_q;
    // Take edge counts as one, frozen once the result shows
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            cnt_q <= 8'h00;
            in_q <= '0;
        end else if (hdr_valid_i && hdr_ready_o) begin
            cnt_q <= 8'h01;
            in_q <= hdr_i;
        end else if (!hdr_valid_o && !hdr_ready_o) begin
            cnt_q <= cnt_q + 8'h01;
        end
    end
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (reset_i);
    ////////////////////////////////////////
    sequence s_take;
        hdr_valid_i && hdr_ready_o;
    endsequence
    sequence s_done;
        hdr_valid_o && hdr_ready_i;
    endsequence
    property p_refuse;
        s_take |=> !hdr_ready_o && !hdr_valid_o || hdr_valid_o && !hdr_ready_o;
    endproperty
    property p_release;
        s_done |=> hdr_ready_o && !hdr_valid_o;
    endproperty
    property p_hold;
        hdr_valid_o && !hdr_ready_i |=> hdr_valid_o && $stable(hdr_o) && $stable(status_o);
    endproperty
    property p_lat_miss;
        $rose(hdr_valid_o) && !status_o.matched |-> cnt_q == 8'h01;
    endproperty
    property p_lat_hit;
        $rose(hdr_valid_o) && status_o.matched |-> cnt_q == 8'(NUM_ACTS + 1);
    endproperty
    property p_pass;
        hdr_valid_o && !status_o.matched |-> hdr_o == in_q && !status_o.hdr_changed;
    endproperty
    property p_src;
        hdr_valid_o |-> hdr_o.source_mac == in_q.source_mac;
    endproperty
    property p_same;
        hdr_valid_o && !status_o.hdr_changed |-> hdr_o == in_q;
    endproperty
    property p_idx;
        hdr_valid_o && status_o.matched |-> rule_valid_i[status_o.rule_index];
    endproperty
    a_refuse: assert property (p_refuse) else $error("taken while busy");
    a_release: assert property (p_release) else $error("no idle after accept");
    a_hold: assert property (p_hold) else $error("result moved while stalled");
    a_lat_miss: assert property (p_lat_miss) else $error("miss latency");
    a_lat_hit: assert property (p_lat_hit) else $error("hit latency");
    a_pass: assert property (p_pass) else $error("unmatched header altered");
    a_src: assert property (p_src) else $error("source address altered");
    a_same: assert property (p_same) else $error("header altered unflagged");
    a_idx: assert property (p_idx) else $error("hit on disabled rule");
endmodule : tfre_engine_sva

bind tfre_engine tfre_engine_sva #(.NUM_RULES(NUM_RULES), .NUM_ACTS(NUM_ACTS)) u_sva (
    .ref_clk_i, .reset_i, .rule_valid_i, .hdr_valid_i, .hdr_i, .hdr_ready_o,
    .hdr_valid_o, .hdr_o, .status_o, .hdr_ready_i
);

/* tb/tb.sv */
`include "tfre_defs.svh"
`define CHK(n, e, a) begin total_checks++; if ((a) !== (e)) begin err_total++; \
    $display("Error %s expected %h seen %h", n, e, a); end end

module tb
    import tfre_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk_i, reset_i, hdr_valid_i, hdr_ready_o, hdr_valid_o, hdr_ready_i;
    logic [3:0] rv, stall;
    tfre_category_t [3:0] cat;
    tfre_cond_t [3:0][3:0] cnd;
    tfre_action_t [3:0][3:0] act;
    tfre_port_role_t role;
    tfre_hdr_t hd, hi, hx, hb, ho, hdr_o;
    tfre_status_t so, status_o;
    int err_total, total_checks;

    tfre_engine #(.IS_EGRESS(1'b0)) dut (
        .ref_clk_i, .reset_i, .rule_valid_i(rv), .rule_category_i(cat), .rule_cond_i(cnd),
        .rule_action_i(act), .port_role_i(role), .hdr_valid_i, .hdr_i(hd), .hdr_ready_o,
        .hdr_valid_o, .hdr_o, .status_o, .hdr_ready_i
    );
    tfre_sink u_sink (.ref_clk_i, .reset_i, .valid_i(hdr_valid_o), .stall_i(stall),
        .ready_o(hdr_ready_i));

    ////////////////////////////////////////
    task finish_test;
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : finish_test
    task clr;
        rv = 4'h0;
        cnd = '0;
        act = '0;
        role = TFRE_PORT_STATION;
        foreach (cat[k]) cat[k] = TFRE_CAT_ENTRANCE;
        stall = 4'h0;
        hi = hb;
    endtask : clr
    task sc(input int r, input int c, input tfre_code_t o, input tfre_code_t f, logic [47:0] v);
        cnd[r][c] = '{o, f, v};
    endtask : sc
    task sa(input int r, input int c, input tfre_code_t o, input tfre_code_t f, logic [47:0] v);
        act[r][c] = '{o, f, v};
    endtask : sa
    // Table must stay put until the result is accepted
    task run;
        int i;
        @(posedge ref_clk_i) #1 hdr_valid_i = 1'b1;
        hd = hi;
        for (i = 0; i < 20 && hdr_ready_o !== 1'b1; i++) @(posedge ref_clk_i) #1;
        if (i == 20) begin
            err_total++;
            finish_test;
        end
        @(posedge ref_clk_i) #1 hdr_valid_i = 1'b0;
        hd = ~hi;
        for (i = 0; i < 20 && !(hdr_valid_o === 1'b1 && hdr_ready_i === 1'b1); i++)
            @(posedge ref_clk_i) #1;
        if (i == 20) begin
            err_total++;
            finish_test;
        end
        ho = hdr_o;
        so = status_o;
        @(posedge ref_clk_i) #1;
    endtask : run
    task ck(input logic c, input logic er, input logic m, input logic [7:0] ix);
        `CHK("hdr_o", hx, ho)
        `CHK("hdr_changed", c, so.hdr_changed)
        `CHK("error", er, so.error)
        `CHK("matched", m, so.matched)
        if (m) `CHK("rule_index", ix, so.rule_index)
    endtask : ck
    ////////////////////////////////////////
    task t_role;
        clr;
        rv = 4'h1;
        cat[0] = TFRE_CAT_EXIT;
        sc(0, 0, `TFRE_OP_TRUE, 8'h00, 48'h0);
        sa(0, 0, `TFRE_ACT_CHANGE, `TFRE_F_DEST_MAC, 48'h0a0b_0c0d_0e0f);
        hx = hi;
        run;
        ck(0, 0, 0, 0);
        role = TFRE_PORT_MANAGER;
        hx.dest_mac = 48'h0a0b_0c0d_0e0f;
        run;
        ck(1, 0, 1, 0);
        role = TFRE_PORT_STATION;
        cat[0] = TFRE_CAT_ENTRANCE;
        run;
        ck(1, 0, 1, 0);
        $display("t_role done");
    endtask : t_role
    task t_change;
        clr;
        stall = 4'h3;
        rv = 4'h1;
        sc(0, 0, `TFRE_OP_EQ, `TFRE_F_ETYPE, 48'h1234);
        sc(0, 1, `TFRE_OP_EQ, `TFRE_F_DEST_MAC, 48'h0011_2233_4455);
        sc(0, 2, `TFRE_OP_EQ, `TFRE_F_PAYLOAD_KIND, 48'h3);
        sa(0, 0, `TFRE_ACT_CHANGE, `TFRE_F_DEST_MAC, 48'h0a0b_0c0d_0e0f);
        sa(0, 1, `TFRE_ACT_CHANGE, `TFRE_F_ETYPE, 48'h5555);
        sa(0, 2, `TFRE_ACT_CHANGE, `TFRE_F_ETYPE, 48'h6666);
        hx = hi;
        hx.dest_mac = 48'h0a0b_0c0d_0e0f;
        hx.ethertype_length = 16'h6666;
        run;
        ck(1, 0, 1, 0);
        hi.kind_present = 1'b0;
        hx = hi;
        run;
        ck(0, 0, 0, 0);
        $display("t_change done");
    endtask : t_change
    task t_vlan;
        clr;
        rv = 4'h1;
        hi.outer_present = 1'b1;
        hi.outer_tag = 32'h8100_a005;
        hi.inner_present = 1'b1;
        hi.inner_tag = 32'h8100_e009;
        sc(0, 0, `TFRE_OP_EQ, `TFRE_F_OUTER_VID, 48'h5);
        sc(0, 1, `TFRE_OP_EQ, `TFRE_F_INNER_VID, 48'h9);
        sc(0, 2, `TFRE_OP_EQ, `TFRE_F_OUTER_TPID, 48'h8100);
        sc(0, 3, `TFRE_OP_EQ, `TFRE_F_INNER_TPID, 48'h8100);
        sa(0, 0, `TFRE_ACT_DELETE, `TFRE_F_OUTER_TAG, 48'h0);
        sa(0, 1, `TFRE_ACT_DELETE, `TFRE_F_INNER_TAG, 48'h0);
        run;
        `CHK("matched", 1'b1, so.matched)
        `CHK("outer_tag", 32'h8100_e009, ho.outer_tag)
        `CHK("presence", 3'b101, {ho.outer_present, ho.inner_present, so.error})
        $display("t_vlan done");
    endtask : t_vlan
    task t_forbid;
        clr;
        rv = 4'h1;
        sa(0, 0, `TFRE_ACT_CHANGE, `TFRE_F_SOURCE_MAC, 48'h1);
        sa(0, 1, `TFRE_ACT_ADD, `TFRE_F_DEST_MAC, 48'h2);
        sa(0, 2, `TFRE_ACT_DELETE, `TFRE_F_ETYPE, 48'h0);
        sa(0, 3, `TFRE_ACT_CHANGE, `TFRE_F_INNER_TAG, 48'h3);
        hx = hi;
        run;
        ck(0, 1, 1, 0);
        $display("t_forbid done");
    endtask : t_forbid
    task t_prio;
        clr;
        stall = 4'h2;
        rv = 4'hf;
        sc(0, 1, `TFRE_OP_EQ, `TFRE_F_ETYPE, 48'h9999);
        sc(1, 0, `TFRE_OP_PRESENT, `TFRE_F_OUTER_TAG, 48'hffff_ffff_ffff);
        sc(2, 0, `TFRE_OP_ABSENT, `TFRE_F_OUTER_TAG, 48'h1);
        sc(2, 1, `TFRE_OP_NE, `TFRE_F_ETYPE, 48'h9999);
        sc(2, 2, `TFRE_OP_PRESENT, `TFRE_F_PAYLOAD_KIND, 48'h0);
        sc(2, 3, `TFRE_OP_TRUE, 8'h00, 48'h0);
        sa(2, 0, `TFRE_ACT_ADD, `TFRE_F_OUTER_TAG, 48'h8100_0007);
        sa(2, 1, `TFRE_ACT_ADD, `TFRE_F_OUTER_TAG, 48'h88a8_0003);
        hx = hi;
        hx.outer_present = 1'b1;
        hx.outer_tag = 32'h88a8_0003;
        hx.inner_present = 1'b1;
        hx.inner_tag = 32'h8100_0007;
        run;
        ck(1, 0, 1, 2);
        rv = 4'h8;
        hx = hi;
        run;
        ck(0, 0, 1, 3);
        $display("t_prio done");
    endtask : t_prio
    task t_kind;
        clr;
        rv = 4'h3;
        sc(0, 0, 8'h55, `TFRE_F_ETYPE, 48'h1234);
        sa(1, 0, `TFRE_ACT_ADD, `TFRE_F_INNER_TAG, 48'h8100_0001);
        sa(1, 1, `TFRE_ACT_ADD, `TFRE_F_INNER_TAG, 48'h8100_0002);
        sa(1, 2, `TFRE_ACT_DELETE, `TFRE_F_PAYLOAD_KIND, 48'h0);
        sa(1, 3, `TFRE_ACT_ADD, `TFRE_F_PAYLOAD_KIND, 48'h7);
        hx = hi;
        hx.outer_present = 1'b1;
        hx.outer_tag = 32'h8100_0001;
        hx.inner_present = 1'b1;
        hx.inner_tag = 32'h8100_0002;
        hx.tunnel_payload_kind = 8'h07;
        run;
        ck(1, 0, 1, 1);
        $display("t_kind done");
    endtask : t_kind
    ////////////////////////////////////////
    initial begin
        ref_clk_i = 1'b0;
        forever #50 ref_clk_i = ~ref_clk_i;
    end
    initial begin
        err_total = 0;
        total_checks = 0;
        reset_i = 1'b1;
        hdr_valid_i = 1'b0;
        hb = '{48'h0011_2233_4455, 48'h0066_7788_99aa, 1'b0, 32'h0, 1'b0, 32'h0, 16'h1234,
            1'b1, 8'h03};
        clr;
        hd = hb;
        repeat (4) @(posedge ref_clk_i);
        #1 reset_i = 1'b0;
        t_role;
        t_change;
        t_vlan;
        t_forbid;
        t_prio;
        t_kind;
        finish_test;
    end
endmodule : tb
